/* lcdcp_top.v */
// lcdcp_top.v: display latch, clock source, timing and power settings
//
// Summary of operation
// - display commands alter only the output latch
// - rc oscillator runs with pin high, no power-save
// - pin low stops oscillator and display clock
// - internal clock divided by 440 per frame
// - external clock divided by 880 per frame
// - timing drives line address, latch, scan, polarity
// - each output picks one of four levels
// - power bits: booster, regulator, follower enables
// - five-bit volume, alpha is its inverse
// - three-bit ratio, code 111 selects external
`timescale 1ns/10ps
`include "lcdcp_defs.vh"
module lcdcp_top (
    // clock and reset
    input  wire                      clk,
    input  wire                      rstn,
    // oscillator control pin, held level or external clock
    input  wire                      osc_control_pin,
    // power save state from the command logic
    input  wire                      power_save,
    // decoded command bytes from the host interface
    input  wire                      cmd_valid,
    input  wire [7:0]                cmd_data,
    // display ram line read port
    output wire [`LCDCP_LINE_W-1:0]  line_addr,
    input  wire [`LCDCP_COLS-1:0]    ram_line_data,
    // panel drivers
    output wire [2*`LCDCP_COLS-1:0]  column_drive_output,
    output wire [2*`LCDCP_LINES-1:0] row_drive_output,
    output wire                      ac_polarity_signal,
    output wire                      scan_cycle_rate,
    output wire                      ext_clock_mode,
    // power supply stage controls
    output wire                      booster_en,
    output wire                      regulator_en,
    output wire                      follower_en,
    output wire [4:0]                contrast_volume,
    output wire [4:0]                alpha_value,
    output wire [2:0]                divider_ratio,
    output wire                      ext_resistor_sel
);
    // display mode state
    reg                       disp_on_q;
    reg                       inverse_q;
    reg                       all_on_q;
    // power settings
    reg [2:0]                 pwr_q;
    reg [4:0]                 vol_q;
    reg [4:0]                 alpha_q;
    reg [2:0]                 ratio_q;
    reg                       ext_res_q;
    // clock source tracking
    wire                      pin_s;
    reg                       pin_d_q;
    reg [`LCDCP_IDLE_W-1:0]   idle_q;
    reg                       ext_q;
    reg [`LCDCP_OSC_W-1:0]    osc_q;
    reg                       osc_tick_q;
    // timing generator
    reg [`LCDCP_PRE_W-1:0]    pre_q;
    reg [`LCDCP_LINE_W-1:0]   line_q;
    reg                       load_q;
    reg                       pol_q;
    reg                       frame_q;
    // output latch
    reg [`LCDCP_COLS-1:0]     pix_q;
    reg [`LCDCP_LINES-1:0]    row_q;

    wire                      pin_change;
    wire                      pin_rise;
    wire                      osc_run;
    wire                      clk_evt;
    wire [`LCDCP_PRE_W-1:0]   pre_last;
    wire                      line_step;
    wire                      line_wrap;
    wire [`LCDCP_COLS-1:0]    col_on;
    wire [`LCDCP_LINES-1:0]   row_on;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_on_q <= 1'b0;
            inverse_q <= 1'b0;
            all_on_q  <= 1'b0;
        end else if (cmd_valid) begin
            if ((cmd_data & `LCDCP_CMD_DISP_MASK) == `LCDCP_CMD_DISP)
                disp_on_q <= cmd_data[0];
            if ((cmd_data & `LCDCP_CMD_DISP_MASK) == `LCDCP_CMD_INV)
                inverse_q <= cmd_data[0];
            if ((cmd_data & `LCDCP_CMD_DISP_MASK) == `LCDCP_CMD_ALLON)
                all_on_q <= cmd_data[0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_q     <= `LCDCP_PWR_RST;
            vol_q     <= `LCDCP_VOL_RST;
            alpha_q   <= ~`LCDCP_VOL_RST;
            ratio_q   <= `LCDCP_RAT_RST;
            ext_res_q <= 1'b0;
        end else if (cmd_valid) begin
            if ((cmd_data & `LCDCP_CMD_PWR_MASK) == `LCDCP_CMD_PWR)
                pwr_q <= cmd_data[2:0];
            if ((cmd_data & `LCDCP_CMD_VOL_MASK) == `LCDCP_CMD_VOL) begin
                vol_q   <= cmd_data[4:0];
                alpha_q <= ~cmd_data[4:0];
            end
            if ((cmd_data & `LCDCP_CMD_RAT_MASK) == `LCDCP_CMD_RAT) begin
                ratio_q   <= cmd_data[2:0];
                ext_res_q <= (cmd_data[2:0] == `LCDCP_RAT_EXT);
            end
        end
    end

    // ------------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------------

    lcdcp_sync u_pin_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (osc_control_pin),
        .dout (pin_s)
    );

    assign pin_change = pin_s ^ pin_d_q;
    assign pin_rise   = pin_s & ~pin_d_q;

    // toggling pin means external clock
    // a single level change after a long quiet spell is a steady high or
    // low setting; only a second change inside the idle window counts as
    // a clock, so the first one or two external edges are not counted
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_d_q <= 1'b0;
            idle_q  <= `LCDCP_IDLE_LAST;
            ext_q   <= 1'b0;
        end else begin
            pin_d_q <= pin_s;
            if (pin_change) begin
                idle_q <= {`LCDCP_IDLE_W{1'b0}};
                if (idle_q != `LCDCP_IDLE_LAST)
                    ext_q <= 1'b1;
            end else if (idle_q != `LCDCP_IDLE_LAST) begin
                idle_q <= idle_q + 1'b1;
            end else begin
                ext_q <= 1'b0;
            end
        end
    end

    // oscillator gated by pin and power save
    assign osc_run = pin_s & ~power_save & ~ext_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_q      <= {`LCDCP_OSC_W{1'b0}};
            osc_tick_q <= 1'b0;
        end else if (!osc_run) begin
            osc_q      <= {`LCDCP_OSC_W{1'b0}};
            osc_tick_q <= 1'b0;
        end else if (osc_q == `LCDCP_OSC_LAST) begin
            osc_q      <= {`LCDCP_OSC_W{1'b0}};
            osc_tick_q <= 1'b1;
        end else begin
            osc_q      <= osc_q + 1'b1;
            osc_tick_q <= 1'b0;
        end
    end

    assign clk_evt  = ext_q ? pin_rise : osc_tick_q;

    assign pre_last = ext_q ? `LCDCP_PRE_EXT_LAST : `LCDCP_PRE_INT_LAST;

    // ------------------------------------------------------------------
    // display timing generator
    // ------------------------------------------------------------------

    assign line_step = clk_evt & (pre_q >= pre_last);
    assign line_wrap = (line_q == `LCDCP_LAST_LINE);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= {`LCDCP_PRE_W{1'b0}};
        end else if (line_step) begin
            pre_q <= {`LCDCP_PRE_W{1'b0}};
        end else if (clk_evt) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // line address, scan and polarity
    // the ram answers the new address in the next cycle, so the latch
    // and the row select load one cycle after the step, together
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_q  <= {`LCDCP_LINE_W{1'b0}};
            load_q  <= 1'b0;
            pol_q   <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            load_q  <= line_step;
            frame_q <= line_step & line_wrap;
            if (line_step) begin
                if (line_wrap) begin
                    line_q <= {`LCDCP_LINE_W{1'b0}};
                    pol_q  <= ~pol_q;
                end else begin
                    line_q <= line_q + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // display data latch
    // ------------------------------------------------------------------

    // latch and scan loaded per line
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_q <= {`LCDCP_COLS{1'b0}};
            row_q <= {`LCDCP_LINES{1'b0}};
        end else if (load_q) begin
            pix_q <= ram_line_data;
            row_q <= {{(`LCDCP_LINES-1){1'b0}}, 1'b1} << line_q;
        end
    end

    // modes shape latch output only
    // the ram image is never written here, so toggling a mode is lossless
    assign col_on = !disp_on_q ? {`LCDCP_COLS{1'b0}} :
                    all_on_q   ? {`LCDCP_COLS{1'b1}} :
                                 (pix_q ^ {`LCDCP_COLS{inverse_q}});
    assign row_on = disp_on_q ? row_q : {`LCDCP_LINES{1'b0}};

    // ------------------------------------------------------------------
    // driver level selection
    // ------------------------------------------------------------------

    lcdcp_level_sel #(
        .N   (`LCDCP_COLS),
        .ROW (0)
    ) u_col_lvl (
        .clk    (clk),
        .rstn   (rstn),
        .on     (col_on),
        .ac_pol (pol_q),
        .lvl    (column_drive_output)
    );

    lcdcp_level_sel #(
        .N   (`LCDCP_LINES),
        .ROW (1)
    ) u_row_lvl (
        .clk    (clk),
        .rstn   (rstn),
        .on     (row_on),
        .ac_pol (pol_q),
        .lvl    (row_drive_output)
    );

    // ------------------------------------------------------------------
    // outputs, all taken from flip-flops
    // ------------------------------------------------------------------

    assign line_addr          = line_q;
    assign ac_polarity_signal = pol_q;
    assign scan_cycle_rate    = frame_q;
    assign ext_clock_mode     = ext_q;

    assign booster_en       = pwr_q[`LCDCP_PWR_BOOST];
    assign regulator_en     = pwr_q[`LCDCP_PWR_REG];
    assign follower_en      = pwr_q[`LCDCP_PWR_FOLLOW];
    assign contrast_volume  = vol_q;
    assign alpha_value      = alpha_q;
    assign divider_ratio    = ratio_q;
    assign ext_resistor_sel = ext_res_q;

endmodule // lcdcp_top

/* lcdcp_defs.vh */
// lcdcp_defs.vh: constants for the lcd clock, timing and power control block
`ifndef LCDCP_DEFS_VH
`define LCDCP_DEFS_VH

// panel geometry
`define LCDCP_COLS          102
`define LCDCP_LINES         55
`define LCDCP_LINE_W        6
`define LCDCP_LAST_LINE     6'h36

// scan clock prescale: 55 lines x 8 internal or x 16 external clocks
`define LCDCP_PRE_W         4
`define LCDCP_PRE_INT_LAST  4'h7
`define LCDCP_PRE_EXT_LAST  4'hf

// internal rc oscillator modelled as one tick per this value plus one clk cycles
`define LCDCP_OSC_W         4
`define LCDCP_OSC_LAST      4'h9

// clk cycles without a pin change before external clock mode is dropped
`define LCDCP_IDLE_W        8
`define LCDCP_IDLE_LAST     8'hff

// command codes and masks
`define LCDCP_CMD_DISP_MASK 8'hfe
`define LCDCP_CMD_DISP      8'hae
`define LCDCP_CMD_INV       8'ha6
`define LCDCP_CMD_ALLON     8'ha4
`define LCDCP_CMD_PWR_MASK  8'hf8
`define LCDCP_CMD_PWR       8'h28
`define LCDCP_CMD_RAT_MASK  8'hf8
`define LCDCP_CMD_RAT       8'h20
`define LCDCP_CMD_VOL_MASK  8'he0
`define LCDCP_CMD_VOL       8'h80

// reset values of the settings, and the external ratio code
`define LCDCP_PWR_RST       3'h0
`define LCDCP_VOL_RST       5'h00
`define LCDCP_RAT_RST       3'h0
`define LCDCP_RAT_EXT       3'h7

// power control bit positions
`define LCDCP_PWR_BOOST     2
`define LCDCP_PWR_REG       1
`define LCDCP_PWR_FOLLOW    0

// four drive levels
`define LCDCP_LVL_0         2'h0
`define LCDCP_LVL_1         2'h1
`define LCDCP_LVL_2         2'h2
`define LCDCP_LVL_3         2'h3

`endif

/* lcdcp_sync.v */
// lcdcp_sync.v: two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
module lcdcp_sync (
    // clock and reset
    input  wire clk,
    input  wire rstn,
    // pin in, synchronised level out
    input  wire din,
    output wire dout
);
    reg meta_q;
    reg sync_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule // lcdcp_sync

/* lcdcp_level_sel.v */
// lcdcp_level_sel.v: registered four-level driver selection per output
`timescale 1ns/10ps
`include "lcdcp_defs.vh"
module lcdcp_level_sel #(
    parameter N   = 8,
    parameter ROW = 0
) (
    // clock and reset
    input  wire           clk,
    input  wire           rstn,
    // selection inputs
    input  wire [N-1:0]   on,
    input  wire           ac_pol,
    // two-bit level code per output
    output wire [2*N-1:0] lvl
);
    reg [2*N-1:0] lvl_q;
    genvar i;

    generate
        for (i = 0; i < N; i = i + 1) begin : g_out
            // rows and columns swing opposite so a selected pixel sees
            // the full voltage; the ac polarity reverses it every frame
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    lvl_q[2*i+1:2*i] <= `LCDCP_LVL_1;
                end else if (ROW != 0) begin
                    if (on[i])
                        lvl_q[2*i+1:2*i] <= ac_pol ? `LCDCP_LVL_3
                                                   : `LCDCP_LVL_0;
                    else
                        lvl_q[2*i+1:2*i] <= ac_pol ? `LCDCP_LVL_1
                                                   : `LCDCP_LVL_2;
                end else begin
                    if (on[i])
                        lvl_q[2*i+1:2*i] <= ac_pol ? `LCDCP_LVL_0
                                                   : `LCDCP_LVL_3;
                    else
                        lvl_q[2*i+1:2*i] <= ac_pol ? `LCDCP_LVL_2
                                                   : `LCDCP_LVL_1;
                end
            end
        end
    endgenerate

    assign lvl = lvl_q;
endmodule // lcdcp_level_sel

/* lcdcp_asserts.sv */
// lcdcp_asserts.sv: port checker for the lcd clock, timing and power block
`timescale 1ns/10ps
`include "lcdcp_defs.vh"
module lcdcp_chk (
    // clock and reset
    input wire                     clk,
    input wire                     rstn,
    // stimulus side
    input wire                     osc_control_pin,
    input wire                     power_save,
    input wire                     cmd_valid,
    input wire [7:0]               cmd_data,
    // timing outputs
    input wire [`LCDCP_LINE_W-1:0] line_addr,
    input wire                     ac_polarity_signal,
    input wire                     scan_cycle_rate,
    input wire                     ext_clock_mode,
    // settings outputs
    input wire                     booster_en,
    input wire                     regulator_en,
    input wire                     follower_en,
    input wire [4:0]               contrast_volume,
    input wire [4:0]               alpha_value,
    input wire [2:0]               divider_ratio,
    input wire                     ext_resistor_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    vol_alpha_a: assert property (
        alpha_value == ~contrast_volume) else $error("alpha mismatch");
    ext_res_a: assert property (
        ext_resistor_sel == (divider_ratio == `LCDCP_RAT_EXT))
        else $error("external resistor select mismatch");
    pwr_cmd_a: assert property (
        cmd_valid && (cmd_data & `LCDCP_CMD_PWR_MASK) == `LCDCP_CMD_PWR
        |=> {booster_en, regulator_en, follower_en} == $past(cmd_data[2:0]))
        else $error("power bits not loaded");
    vol_cmd_a: assert property (
        cmd_valid && (cmd_data & `LCDCP_CMD_VOL_MASK) == `LCDCP_CMD_VOL
        |=> contrast_volume == $past(cmd_data[4:0]))
        else $error("volume not loaded");
    rat_cmd_a: assert property (
        cmd_valid && (cmd_data & `LCDCP_CMD_RAT_MASK) == `LCDCP_CMD_RAT
        |=> divider_ratio == $past(cmd_data[2:0]))
        else $error("ratio not loaded");
    hold_set_a: assert property (
        !cmd_valid |=> $stable({booster_en, regulator_en, follower_en,
        contrast_volume, divider_ratio})) else $error("setting drifted");
    osc_stop_a: assert property (
        !osc_control_pin [*8] |=> $stable(line_addr))
        else $error("timing ran with pin low");
    psave_stop_a: assert property (
        power_save [*4] ##0 !ext_clock_mode |=> $stable(line_addr))
        else $error("timing ran in power save");
    frame_wrap_a: assert property (
        scan_cycle_rate |-> line_addr == 6'h00 &&
        ac_polarity_signal != $past(ac_polarity_signal))
        else $error("frame pulse without wrap");
    cover property (scan_cycle_rate);
    cover property ($rose(ext_clock_mode));
    cover property (cmd_valid && cmd_data == 8'h2b);
endmodule // lcdcp_chk

/* lcdcp_panel.sv */
// lcdcp_panel.sv: far side model, display ram lines and clock pin source
`timescale 1ns/10ps
module lcdcp_panel (
    // clock
    input  wire         clk,
    // 0 pin low, 1 pin high, 2 external clock
    input  wire [1:0]   mode,
    output logic        osc_control_pin,
    // display ram read port
    input  wire [5:0]   line_addr,
    output wire [101:0] ram_line_data
);
    logic ph_q = 1'b0;
    // fixed pattern per line, the block has no way to write it
    assign ram_line_data = {17{line_addr ^ 6'h2a}};
    initial osc_control_pin = 1'b1;
    always @(posedge clk) begin
        ph_q <= ~ph_q;
        if (mode == 2'h2) begin
            if (ph_q)
                osc_control_pin <= ~osc_control_pin;
        end else begin
            osc_control_pin <= (mode == 2'h1);
        end
    end
endmodule // lcdcp_panel

/* tb.sv */
// tb.sv: self-checking bench for the lcd clock, timing and power block
`timescale 1ns/10ps
`include "lcdcp_defs.vh"
module tb;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         power_save = 1'b0;
    logic         cmd_valid = 1'b0;
    logic [7:0]   cmd_data = 8'h00;
    logic [1:0]   mode = 2'h1;
    wire          osc_control_pin, ac_polarity_signal, scan_cycle_rate;
    wire          ext_clock_mode, booster_en, regulator_en, follower_en;
    wire          ext_resistor_sel;
    wire  [5:0]   line_addr;
    wire  [101:0] ram_line_data;
    wire  [203:0] column_drive_output;
    wire  [109:0] row_drive_output;
    wire  [4:0]   contrast_volume, alpha_value;
    wire  [2:0]   divider_ratio;
    logic [2:0]   ep = 3'h0, er = 3'h0;
    logic [4:0]   ev = 5'h00;
    logic [7:0]   r;
    logic [16:0]  q[$];
    logic         tk = 1'b0;
    integer       n_errors = 0, num_checks = 0, cyc = 0, seed = 5, i, k;
    logic [2:0]   pwr_tab [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    logic [2:0]   dsp_tab [5] = '{3'h4, 3'h6, 3'h7, 3'h5, 3'h3};

    always #20 clk = ~clk;

    lcdcp_top dut (.clk, .rstn, .osc_control_pin, .power_save, .cmd_valid,
        .cmd_data, .line_addr, .ram_line_data, .column_drive_output,
        .row_drive_output, .ac_polarity_signal, .scan_cycle_rate,
        .ext_clock_mode, .booster_en, .regulator_en, .follower_en,
        .contrast_volume, .alpha_value, .divider_ratio, .ext_resistor_sel);
    lcdcp_panel u_panel (.clk, .mode, .osc_control_pin, .line_addr,
        .ram_line_data);

    task end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task check(input string nm, input logic [203:0] s, input logic [203:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task tick;
        @(posedge clk);
        #1;
    endtask

    // caller lowers cmd_valid, so back-to-back sends never double-drive it
    task send(input logic [7:0] b);
        cmd_data = b;
        cmd_valid = 1'b1;
        if ((b & `LCDCP_CMD_PWR_MASK) == `LCDCP_CMD_PWR) ep = b[2:0];
        if ((b & `LCDCP_CMD_VOL_MASK) == `LCDCP_CMD_VOL) ev = b[4:0];
        if ((b & `LCDCP_CMD_RAT_MASK) == `LCDCP_CMD_RAT) er = b[2:0];
        q.push_back({ep, ev, ~ev, er, er == `LCDCP_RAT_EXT});
        tick;
    endtask

    always @(posedge clk) begin
        if (tk)
            check("settings", {booster_en, regulator_en, follower_en,
                contrast_volume, alpha_value, divider_ratio,
                ext_resistor_sel}, q.pop_front());
        tk = cmd_valid;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            end_of_test;
        end
    end

    // m: display on, inverse, all on
    task chk_lvl(input logic [2:0] m);
        logic [203:0] ec;
        logic [109:0] rw;
        logic [101:0] d;
        logic [5:0]   n;
        logic         f, on;
        n = line_addr;
        for (k = 0; k < 200 && line_addr === n; k++)
            tick;
        repeat (10) tick;
        n = line_addr;
        f = ac_polarity_signal;
        d = {17{n ^ 6'h2a}};
        for (k = 0; k < 102; k++) begin
            on = m[2] & (m[0] | (d[k] ^ m[1]));
            ec[2*k +: 2] = on ? (f ? 2'h0 : 2'h3) : (f ? 2'h2 : 2'h1);
        end
        for (k = 0; k < 55; k++)
            rw[2*k +: 2] = (m[2] && n == k) ? (f ? 2'h3 : 2'h0)
                                            : (f ? 2'h1 : 2'h2);
        check("columns", column_drive_output, ec);
        check("rows", row_drive_output, rw);
    endtask

    task period(input integer e, input string nm);
        integer c;
        for (c = 0; c < 9000 && scan_cycle_rate !== 1'b1; c++)
            tick;
        tick;
        for (c = 1; c < 9000 && scan_cycle_rate !== 1'b1; c++)
            tick;
        check(nm, c, e);
    endtask

    task stall(input string nm);
        logic [5:0] n;
        integer     p;
        repeat (20) tick;
        n = line_addr;
        p = 0;
        repeat (5000) begin
            tick;
            p = p + scan_cycle_rate;
        end
        check(nm, {line_addr, p[7:0]}, {n, 8'h00});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        check("reset", {booster_en, regulator_en, follower_en,
            contrast_volume, alpha_value, divider_ratio, ext_resistor_sel},
            {3'h0, 5'h00, 5'h1f, 3'h0, 1'b0});
        check("reset cols", column_drive_output, {102{2'h1}});
        check("reset rows", row_drive_output, {55{2'h1}});
        send(8'h2b);
        send(8'h90);
        send(8'h27);
        send(8'h80);
        send(8'h9f);
        send(8'h20);
        for (i = 0; i < 40; i++) begin
            k = $random(seed) & 3;
            r = $random(seed);
            case (k)
                0: send({5'h05, pwr_tab[r[1:0]]});
                1: send({3'h4, r[4:0]});
                2: send({5'h04, r[2:0]});
                default: send({r[7] | 1'b1, r[6:0]});
            endcase
        end
        for (i = 0; i < 5; i++) begin
            send({7'h57, dsp_tab[i][2]});
            send({7'h53, dsp_tab[i][1]});
            send({7'h52, dsp_tab[i][0]});
            cmd_valid = 1'b0;
            chk_lvl(dsp_tab[i]);
        end
        period((`LCDCP_OSC_LAST + 1) * 440, "int frame");
        mode = 2'h2;
        for (i = 0; i < 600 && ext_clock_mode !== 1'b1; i++)
            tick;
        period(4 * 880, "ext frame");
        mode = 2'h0;
        repeat (300) tick;
        check("ext mode", ext_clock_mode, 1'b0);
        stall("pin low");
        mode = 2'h1;
        power_save = 1'b1;
        stall("power save");
        power_save = 1'b0;
        period((`LCDCP_OSC_LAST + 1) * 440, "resume");
        end_of_test;
    end
endmodule // tb

bind lcdcp_top lcdcp_chk u_chk (.clk, .rstn, .osc_control_pin, .power_save,
    .cmd_valid, .cmd_data, .line_addr, .ac_polarity_signal,
    .scan_cycle_rate, .ext_clock_mode, .booster_en, .regulator_en,
    .follower_en, .contrast_volume, .alpha_value, .divider_ratio,
    .ext_resistor_sel);
